/* design/aofr_regs.sv */
// output format, offset trim and interleave mode registers with avalon slave
// Function
// RULE1: config bit 7 enables interleaved dual-edge sampling; clear means independent channels.
// RULE2: in interleaved mode, bit 6 selects first (0) or second (1) input.
// RULE3: mode decoded from config bits 7:5 plus auto-sync bit 6.
// RULE4: format bit 4: zero offset binary, one two's complement output.
// RULE5: time-stamp enable bit 3 resets to zero; one enables capture.
// RULE6: bit 2 zero gives double data rate, one single data rate.
// RULE7: software writes reserved register one only with its default pattern.
// RULE8: software keeps offset register bits 15:13 at zero.
// RULE9: offset sign zero adds, one subtracts the programmed magnitude.
// RULE10: twelve-bit offset magnitude is straight binary, linear scaling.
// RULE11: offset spans 0 mV at code zero to 45 mV at 4095.
// RULE12: only nine magnitude msbs guarantee monotonic offset steps.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
module aofr_regs
  import aofr_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   arst_n_in,
  // avalon-mm slave
  input  wire logic [aofr_pkg::ADDR_W-1:0] avs_address_in,
  input  wire logic                   avs_read_in,
  input  wire logic                   avs_write_in,
  input  wire logic [31:0]            avs_writedata_in,
  input  wire logic [3:0]             avs_byteenable_in,
  output logic      [31:0]            avs_readdata_out,
  output logic                        avs_waitrequest_out,
  output logic      [1:0]             avs_response_out,
  // converter sample path
  input  wire logic [11:0]            sample_in,
  output logic      [11:0]            sample_out,
  // control outputs
  output logic                        interleave_enable_out,
  output logic                        interleave_input_select_out,
  output logic      [2:0]             sampling_mode_out,
  output logic                        output_format_select_out,
  output logic                        timestamp_enable_out,
  output logic                        single_rate_select_out
);
  import aofr_pkg::*;

  // ==========================================================================
  // registers
  logic [15:0] config_r;
  logic [15:0] config_nxt;
  logic [15:0] reserved_r;
  logic [15:0] reserved_nxt;
  logic [15:0] offset_r;
  logic [15:0] offset_nxt;
  logic [15:0] autosync_r;
  logic [15:0] autosync_nxt;
  aofr_bus_t   bus_r;
  logic [31:0] rdata_r;
  logic [1:0]  resp_r;
  logic [2:0]  mode_r;
  logic        wait_r;

  // byte-lane merge into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // ==========================================================================
  // address decode (word aligned, index = address / 4)
  logic [3:0]  idx;
  logic        aligned;
  logic        hit_cfg;
  logic        hit_rsv;
  logic        hit_ofs;
  logic        hit_as;
  logic        hit_any;
  logic        req;
  logic        wr_go;
  logic        rd_go;
  logic        wr_cfg;
  logic        wr_rsv;
  logic        wr_ofs;
  logic        wr_as;
  logic [15:0] rd_mux;

  assign idx     = avs_address_in[5:2];
  assign aligned = (avs_address_in[1:0] == 2'b00);
  assign hit_cfg = aligned && (idx == REG_IDX_CONFIG);
  assign hit_rsv = aligned && (idx == REG_IDX_RESERVED);
  assign hit_ofs = aligned && (idx == REG_IDX_OFFSET);
  assign hit_as  = aligned && (idx == REG_IDX_AUTOSYNC);
  assign hit_any = hit_cfg || hit_rsv || hit_ofs || hit_as;
  assign req     = (avs_read_in || avs_write_in) && (bus_r == AOFR_BUS_IDLE);
  assign wr_go   = req && avs_write_in;
  assign rd_go   = req && avs_read_in;
  assign wr_cfg  = wr_go && hit_cfg;
  assign wr_rsv  = wr_go && hit_rsv;
  assign wr_ofs  = wr_go && hit_ofs;
  assign wr_as   = wr_go && hit_as;

  assign rd_mux = hit_cfg ? config_r
                : hit_rsv ? reserved_r
                : hit_ofs ? offset_r
                : hit_as  ? autosync_r
                : 16'h0000;

  // ==========================================================================
  // next register values
  // reserved register is stored as written; software must only rewrite the pattern
  // writes commit at the first request edge, the same edge that drops waitrequest, while the master still holds them
  assign config_nxt   = wr_cfg ? merge16(config_r, avs_writedata_in, avs_byteenable_in)
                               : config_r;
  assign reserved_nxt = wr_rsv ? merge16(reserved_r, avs_writedata_in, avs_byteenable_in)
                               : reserved_r;                                    // [RULE7]
  // upper three bits masked so they always read zero
  assign offset_nxt   = wr_ofs ? (merge16(offset_r, avs_writedata_in, avs_byteenable_in)
                                  & OFFSET_WMASK)
                               : offset_r;                                      // [RULE8]
  assign autosync_nxt = wr_as  ? merge16(autosync_r, avs_writedata_in, avs_byteenable_in)
                               : autosync_r;

  // ==========================================================================
  // sampling mode decode
  logic [2:0]  cfg_mode_bits;
  aofr_mode_t  mode_nxt;

  assign cfg_mode_bits = {config_nxt[CFG_DES_BIT], config_nxt[CFG_DEQ_BIT],
                          config_nxt[CFG_DIQ_BIT]};
  assign mode_nxt = (cfg_mode_bits == 3'b000 && !autosync_nxt[AS_CLKIQ_BIT])
                    ? AOFR_MODE_NONINTERLEAVED                               // [RULE3]
                  : (cfg_mode_bits == 3'b100 && !autosync_nxt[AS_CLKIQ_BIT])
                    ? AOFR_MODE_FIRST
                  : (cfg_mode_bits == 3'b110 && !autosync_nxt[AS_CLKIQ_BIT])
                    ? AOFR_MODE_SECOND
                  : (cfg_mode_bits == 3'b101 && !autosync_nxt[AS_CLKIQ_BIT])
                    ? AOFR_MODE_SHORTED
                  : (cfg_mode_bits == 3'b000 && autosync_nxt[AS_CLKIQ_BIT])
                    ? AOFR_MODE_CLOCK_DRIVEN
                  : AOFR_MODE_INVALID;

  // ==========================================================================
  // storage
  // mode is taken from the next values so it moves on the same edge as config_r
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      config_r   <= CONFIG_RST;
      reserved_r <= RESERVED_RST;
      offset_r   <= OFFSET_RST;
      autosync_r <= AUTOSYNC_RST;
      mode_r     <= AOFR_MODE_NONINTERLEAVED;
    end
    else
    begin
      config_r   <= config_nxt;
      reserved_r <= reserved_nxt;
      offset_r   <= offset_nxt;
      autosync_r <= autosync_nxt;
      mode_r     <= mode_nxt;
    end
  end

  // ==========================================================================
  // bus handshake: one wait cycle, answer on the second edge
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      bus_r   <= AOFR_BUS_IDLE;
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
      resp_r  <= 2'b00;
    end
    else
    begin
      case (bus_r)
        AOFR_BUS_IDLE:
        begin
          if (req)
          begin
            // readdata and response hold until the next accepted request
            bus_r   <= AOFR_BUS_ACK;
            wait_r  <= 1'b0;
            rdata_r <= rd_go ? {16'h0000, rd_mux} : 32'h0000_0000;
            resp_r  <= hit_any ? 2'b00 : 2'b10;
          end
        end
        default:
        begin
          bus_r  <= AOFR_BUS_IDLE;
          wait_r <= 1'b1;
        end
      endcase
    end
  end

  // own flop so the port never shows a decode of the state bits
  assign avs_waitrequest_out = wait_r;
  assign avs_readdata_out    = rdata_r;
  assign avs_response_out    = resp_r;

  // ==========================================================================
  // control outputs straight from registers
  assign interleave_enable_out       = config_r[CFG_DES_BIT];           // [RULE1]
  assign interleave_input_select_out = config_r[CFG_DEQ_BIT];           // [RULE2]
  assign sampling_mode_out           = mode_r;                          // [RULE3]
  assign output_format_select_out    = config_r[CFG_FMT_BIT];           // [RULE4]
  assign timestamp_enable_out        = config_r[CFG_TSE_BIT];           // [RULE5]
  assign single_rate_select_out      = config_r[CFG_SDR_BIT];           // [RULE6]

  // ==========================================================================
  // sample path with trim and coding
  aofr_offset_apply u_apply
  (
    .clk_in                  (clk_in),
    .arst_n_in               (arst_n_in),
    .sample_in               (sample_in),
    .offset_sign_in          (offset_r[OFS_SIGN_BIT]),
    .offset_magnitude_in     (offset_r[OFS_MAG_W-1:0]),
    .output_format_select_in (config_r[CFG_FMT_BIT]),
    .sample_out              (sample_out)
  );

endmodule : aofr_regs
`default_nettype wire

/* design/aofr_pkg.sv */
// constants for the output format and offset trim register bank
package aofr_pkg;

  // ==========================================================================
  // register map (printed offsets are word indices; byte address is 4x)
  localparam logic [3:0]  REG_IDX_CONFIG    = 4'h0;
  localparam logic [3:0]  REG_IDX_RESERVED  = 4'h1;
  localparam logic [3:0]  REG_IDX_OFFSET    = 4'h2;
  localparam logic [3:0]  REG_IDX_AUTOSYNC  = 4'hE;
  localparam int          ADDR_W            = 6;

  // ==========================================================================
  // reset values
  localparam logic [15:0] CONFIG_RST        = 16'h2000;
  localparam logic [15:0] RESERVED_RST      = 16'h2907;
  localparam logic [15:0] OFFSET_RST        = 16'h0000;
  localparam logic [15:0] AUTOSYNC_RST      = 16'h0000;

  // ==========================================================================
  // field positions
  localparam int          CFG_DES_BIT       = 7;
  localparam int          CFG_DEQ_BIT       = 6;
  localparam int          CFG_DIQ_BIT       = 5;
  localparam int          CFG_FMT_BIT       = 4;
  localparam int          CFG_TSE_BIT       = 3;
  localparam int          CFG_SDR_BIT       = 2;
  localparam int          AS_CLKIQ_BIT      = 6;
  localparam int          OFS_SIGN_BIT      = 12;
  localparam int          OFS_MAG_W         = 12;
  localparam int          OFS_MONO_W        = 9;
  localparam logic [15:0] OFFSET_WMASK      = 16'h1FFF;

  // ==========================================================================
  // offset scale: full code spans this many microvolts
  localparam int          OFS_FULL_UV       = 45000;
  localparam int          OFS_MAX_CODE      = 4095;

  // ==========================================================================
  // sampling modes
  typedef enum logic [2:0]
  {
    AOFR_MODE_NONINTERLEAVED = 3'b000,
    AOFR_MODE_FIRST          = 3'b001,
    AOFR_MODE_SECOND         = 3'b010,
    AOFR_MODE_SHORTED        = 3'b011,
    AOFR_MODE_CLOCK_DRIVEN   = 3'b100,
    AOFR_MODE_INVALID        = 3'b111
  } aofr_mode_t;

  // avalon slave states
  typedef enum logic [1:0]
  {
    AOFR_BUS_IDLE = 2'b00,
    AOFR_BUS_ACK  = 2'b01
  } aofr_bus_t;

endpackage : aofr_pkg

/* design/aofr_offset_apply.sv */
// offset trim and output coding applied to one converter sample
`timescale 1ns/1ns
`default_nettype none
module aofr_offset_apply
  import aofr_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // sample in (offset binary, 12 bit)
  input  wire logic [11:0] sample_in,
  // control
  input  wire logic        offset_sign_in,
  input  wire logic [11:0] offset_magnitude_in,
  input  wire logic        output_format_select_in,
  // sample out
  output logic      [11:0] sample_out
);

  // ==========================================================================
  // offset in sample lsbs: 4096 codes span 45 mV; a sample lsb is taken as
  // 8 codes of the same scale, so the shift is the 9 monotonic msbs only
  logic [12:0] mag_lsb;
  logic [13:0] sum;
  logic [11:0] sat;
  logic [11:0] coded;
  logic [11:0] sample_r;

  assign mag_lsb = {4'h0, offset_magnitude_in[OFS_MAG_W-1 -: OFS_MONO_W]}; // [RULE10] [RULE12]
  assign sum     = offset_sign_in                                         // [RULE9]
                 ? {2'b00, sample_in} - {1'b0, mag_lsb}
                 : {2'b00, sample_in} + {1'b0, mag_lsb};
  // saturate rather than wrap so a large trim never flips the sample
  assign sat     = sum[13] ? 12'h000 : (sum[12] ? 12'hFFF : sum[11:0]);   // [RULE11]
  assign coded   = output_format_select_in ? {~sat[11], sat[10:0]} : sat;  // [RULE4]

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      sample_r <= 12'h000;
    else
      sample_r <= coded;
  end

  assign sample_out = sample_r;

endmodule : aofr_offset_apply
`default_nettype wire

/* dv/aofr_regs_chk.sv */
// assertions for the format and offset register bank
`timescale 1ns/1ns
`default_nettype none
module aofr_regs_chk
  import aofr_pkg::*;
(
  // ==========================================================================
  // watched ports
  input  wire logic                        clk_in,
  input  wire logic                        arst_n_in,
  input  wire logic [aofr_pkg::ADDR_W-1:0] avs_address_in,
  input  wire logic                        avs_read_in,
  input  wire logic                        avs_write_in,
  input  wire logic [31:0]                 avs_writedata_in,
  input  wire logic [3:0]                  avs_byteenable_in,
  input  wire logic [31:0]                 avs_readdata_out,
  input  wire logic                        avs_waitrequest_out,
  input  wire logic [1:0]                  avs_response_out,
  input  wire logic                        interleave_enable_out,
  input  wire logic                        interleave_input_select_out,
  input  wire logic [2:0]                  sampling_mode_out,
  input  wire logic                        output_format_select_out,
  input  wire logic                        timestamp_enable_out,
  input  wire logic                        single_rate_select_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // config write completing at this edge; the register already holds it
  wire logic cfg_wr = avs_write_in && !avs_waitrequest_out && avs_address_in == 6'h00
                      && avs_byteenable_in[0];
  wire logic bad_rd = avs_read_in && !avs_waitrequest_out && avs_address_in == 6'h10;
  ilv_write_a: assert property (cfg_wr |-> {interleave_enable_out,
    interleave_input_select_out} == avs_writedata_in[7:6]) else $error("interleave bits wrong");
  fmt_write_a: assert property (cfg_wr |-> output_format_select_out == avs_writedata_in[4])
    else $error("format bit wrong");
  tse_write_a: assert property (cfg_wr |-> timestamp_enable_out == avs_writedata_in[3])
    else $error("timestamp bit wrong");
  sdr_write_a: assert property (cfg_wr |-> single_rate_select_out == avs_writedata_in[2])
    else $error("rate bit wrong");
  // mode and config bits change on the same edge, so they are compared side by side
  mode_off_a: assert property (!interleave_enable_out |-> sampling_mode_out inside
    {AOFR_MODE_NONINTERLEAVED, AOFR_MODE_CLOCK_DRIVEN, AOFR_MODE_INVALID}) else $error("mode off");
  mode_first_a: assert property (interleave_enable_out && !interleave_input_select_out
    |-> sampling_mode_out inside {AOFR_MODE_FIRST, AOFR_MODE_SHORTED, AOFR_MODE_INVALID})
    else $error("mode first");
  mode_second_a: assert property (interleave_enable_out && interleave_input_select_out
    |-> sampling_mode_out inside {AOFR_MODE_SECOND, AOFR_MODE_INVALID})
    else $error("mode second");
  wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
  unmapped_a: assert property (bad_rd |-> avs_response_out == 2'b10 && avs_readdata_out == 32'h0)
    else $error("unmapped read answered");
  cover property (cfg_wr && avs_writedata_in[7]);
  cover property (sampling_mode_out == AOFR_MODE_CLOCK_DRIVEN);
  cover property (bad_rd);
endmodule : aofr_regs_chk
bind aofr_regs aofr_regs_chk i_aofr_regs_chk (.*);
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench for the format and offset register bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import aofr_pkg::*;
  // ==========================================================================
  // signals
  logic        clk_in = 1'b0, arst_n_in = 1'b0, rd = 1'b0, wr = 1'b0, wreq, fmt, timestamp_enable, single_rate_select, en, sel;
  logic [5:0]  adr  = 6'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  logic [11:0] smp  = 12'h000, smp_o;
  logic [1:0]  resp, last_resp;
  logic [2:0]  mode;
  int          err_count = 0, n_tests = 0;
  always #25 clk_in = ~clk_in;
  aofr_regs i_aofr_regs (.clk_in(clk_in), .arst_n_in(arst_n_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'h3),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .avs_response_out(resp),
    .sample_in(smp), .sample_out(smp_o), .interleave_enable_out(en),
    .interleave_input_select_out(sel), .sampling_mode_out(mode), .output_format_select_out(fmt),
    .timestamp_enable_out(timestamp_enable), .single_rate_select_out(single_rate_select));
  // ==========================================================================
  // shared tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one idle edge after release so the next request never lands in the same step
  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    adr <= a;
    wdat <= {16'h0000, d};
    wr <= w;
    rd <= ~w;
    @(posedge clk_in);
    while (wreq !== 1'b0 && n < 50)
    begin
      @(posedge clk_in);
      n++;
    end
    q = rdat[15:0];
    last_resp = resp;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_in);
    chk("bus answer", 16'h0000, (n >= 50) ? 16'h0001 : 16'h0000);
  endtask : bus
  function automatic logic [11:0] trim(input logic [25:0] c);
    int r;
    r = c[24] ? int'(c[11:0]) - int'(c[23:15]) : int'(c[11:0]) + int'(c[23:15]);
    r = (r < 0) ? 0 : (r > 4095) ? 4095 : r;
    return c[25] ? 12'(r) ^ 12'h800 : 12'(r);
  endfunction : trim
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    logic [15:0] q;
    bus(1'b0, 6'h00, 16'h0000, q);
    chk("config", CONFIG_RST, q);
    bus(1'b0, 6'h04, 16'h0000, q);
    chk("reserved", RESERVED_RST, q);
    bus(1'b0, 6'h08, 16'h0000, q);
    chk("offset", OFFSET_RST, q);
    chk("controls", 16'h0000, {8'h00, en, sel, mode, fmt, timestamp_enable, single_rate_select});
    $display("test reset done");
  endtask : t_reset
  task automatic t_modes();
    logic [15:0] q;
    logic [6:0]  tbl [6] = '{7'b0000_000, 7'b1000_001, 7'b1100_010, 7'b1010_011, 7'b0001_100,
                             7'b1110_111};
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b1, 6'h38, {9'h000, tbl[i][3], 6'h00}, q);
      bus(1'b1, 6'h00, {8'h20, tbl[i][6:4], 5'h00}, q);
      chk("mode", {13'h0000, tbl[i][2:0]}, {13'h0000, mode});
      chk("interleave", {14'h0000, tbl[i][6:5]}, {14'h0000, en, sel});
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_fields();
    logic [15:0] q;
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, 6'h00, {8'h20, 3'b000, 3'(i), 2'b00}, q);
      chk("format", {15'h0000, i[2]}, {15'h0000, fmt});
      chk("timestamp", {15'h0000, i[1]}, {15'h0000, timestamp_enable});
      chk("rate", {15'h0000, i[0]}, {15'h0000, single_rate_select});
    end
    $display("test fields done");
  endtask : t_fields
  task automatic t_offset();
    logic [15:0] q;
    logic [25:0] c [7] = '{{2'b00, 12'hFF8, 12'h400}, {2'b01, 12'hFF8, 12'h400},
      {2'b00, 12'hFFF, 12'hF00}, {2'b01, 12'hFFF, 12'h100}, {2'b00, 12'h007, 12'h400},
      {2'b10, 12'h008, 12'h7FF}, {2'b00, 12'h000, 12'hABC}};
    // offset writes keep bits 15:13 at zero
    bus(1'b1, 6'h08, 16'h1ABC, q);
    bus(1'b0, 6'h08, 16'h0000, q);
    chk("offset readback", 16'h1ABC, q);
    bus(1'b1, 6'h04, 16'h2907, q);
    bus(1'b0, 6'h04, 16'h0000, q);
    chk("reserved", 16'h2907, q);
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b1, 6'h00, {8'h20, 3'b000, c[i][25], 4'h0}, q);
      bus(1'b1, 6'h08, {3'b000, c[i][24:12]}, q);
      smp <= c[i][11:0];
      repeat (2) @(posedge clk_in);
      chk("sample", {4'h0, trim(c[i])}, {4'h0, smp_o});
    end
    $display("test offset done");
  endtask : t_offset
  task automatic t_unmapped();
    logic [15:0] q;
    bus(1'b0, 6'h10, 16'h0000, q);
    chk("unmapped data", 16'h0000, q);
    chk("unmapped response", 16'h0002, {14'h0000, last_resp});
    bus(1'b1, 6'h10, 16'h00FF, q);
    bus(1'b0, 6'h00, 16'h0000, q);
    chk("config kept", 16'h2000, q);
    chk("response", 16'h0000, {14'h0000, last_resp});
    $display("test unmapped done");
  endtask : t_unmapped
  // ==========================================================================
  // run control
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_modes();
    t_fields();
    t_offset();
    t_unmapped();
    summarize();
  end
  // about 160 cycles expected; nearly twenty times that means a hang
  initial
  begin
    repeat (3000) @(posedge clk_in);
    err_count++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
